// ==== src/brp_fifo.sv ====
`timescale 1ns/1ps
module brp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_flush,
    // Fill side
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    // Drain side
    output logic                  o_valid,
    output logic [WIDTH-1:0]      o_data,
    input  wire logic             i_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_ready = (cnt_q != (AW+1)'(DEPTH));
    assign o_valid = (cnt_q != '0);
    assign o_data  = mem_q[rd_q];
    assign push    = i_valid && o_ready;
    assign pop     = o_valid && i_ready;

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn || i_flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ==== src/brp_pkg.sv ====
package brp_pkg;
    // ----------------------------------------
    // Array geometry
    // ----------------------------------------
    localparam int ADDR_W      = 17;
    localparam int DATA_W      = 8;
    localparam int BYTE_SEL_W  = 2;
    localparam int DEPTH       = 131072;
    localparam logic [BYTE_SEL_W-1:0] BYTE_LAST = 2'h3;
    localparam logic [BYTE_SEL_W-1:0] BYTE_ONE  = 2'h1;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int WAIT_DEFAULT = 2;
    localparam int FIFO_DEPTH   = 8;
    localparam int CLK_NS       = 40;
    localparam logic [1:0] WAIT_ONE = 2'h1;

    typedef enum logic [2:0] {
        BRP_IDLE,
        BRP_ADDR,
        BRP_WAIT,
        BRP_DATA,
        BRP_RECOVER
    } brp_state_t;
endpackage

// ==== src/brp_rom.sv ====
`timescale 1ns/1ps
module brp_rom
    import brp_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // Clock
    input  wire logic              i_clk,
    // Read port, one cycle latency
    input  wire logic [AW-1:0]     i_addr,
    output logic      [DATA_W-1:0] o_data,
    // Load port for the programming path
    input  wire logic              i_wr,
    input  wire logic [DATA_W-1:0] i_wdata
);
    // Storage is plain flip-flops; a real part maps this to its array
    logic [DATA_W-1:0] mem_q [2**AW];

    always_ff @(posedge i_clk) begin
        if (i_wr) begin
            mem_q[i_addr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_data <= mem_q[i_addr];
    end
endmodule

// ==== src/brp_top.sv ====
`timescale 1ns/1ps
module brp_top
    import brp_pkg::*;
#(
    parameter int WAIT_CYCLES = WAIT_DEFAULT,
    parameter int FDEPTH      = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    // Burst bus from the master
    input  wire logic              i_select_n,
    input  wire logic              i_addr_valid_strobe_n,
    input  wire logic              i_final_beat_n,
    input  wire logic [ADDR_W-1:0] i_byte_address,
    // Programming path
    input  wire logic              i_program_pulse_n,
    input  wire logic [DATA_W-1:0] i_byte_data,
    // Data pins as two signals
    output logic      [DATA_W-1:0] o_byte_data,
    output logic                   o_byte_data_oe_n,
    // Stream side
    output logic                   o_beat_valid,
    output logic      [DATA_W-1:0] o_beat_data,
    input  wire logic              i_beat_ready,
    // Status
    output logic                   o_busy
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic [ADDR_W-1:0] addr_meta_q;
    logic [ADDR_W-1:0] addr_sync_q;
    logic [DATA_W-1:0] wd_meta_q;
    logic [DATA_W-1:0] wd_sync_q;
    logic sel_n;
    logic ads_n;
    logic last_n;
    logic pgm_n;
    logic ads_prev_q;
    logic pgm_prev_q;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            meta_q <= 4'hf;
            sync_q <= 4'hf;
        end else begin
            meta_q <= {i_program_pulse_n, i_final_beat_n,
                       i_addr_valid_strobe_n, i_select_n};
            sync_q <= meta_q;
        end
    end

    always_ff @(posedge i_clk) begin
        addr_meta_q <= i_byte_address;
        addr_sync_q <= addr_meta_q;
        wd_meta_q   <= i_byte_data;
        wd_sync_q   <= wd_meta_q;
    end

    assign sel_n  = sync_q[0];
    assign ads_n  = sync_q[1];
    assign last_n = sync_q[2];
    assign pgm_n  = sync_q[3];

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            ads_prev_q <= 1'b1;
            pgm_prev_q <= 1'b1;
        end else begin
            ads_prev_q <= ads_n;
            pgm_prev_q <= pgm_n;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    brp_state_t state_q;
    brp_state_t state_d;
    logic [1:0] wait_q;
    logic [BYTE_SEL_W-1:0] beats_q;
    logic [ADDR_W-1:0] latch_q;
    logic [BYTE_SEL_W-1:0] byte_q;
    logic fifo_ready;
    logic emit;
    logic [DATA_W-1:0] rom_data;
    logic [ADDR_W-1:0] rom_addr;
    logic pgm_write;

    // Data beats also require the stream to have room; a full buffer
    // stalls the sequencer rather than dropping a byte
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            BRP_IDLE: begin
                if (!sel_n && pgm_n) begin
                    state_d = BRP_ADDR;
                end
            end
            BRP_ADDR: begin
                state_d = BRP_WAIT;
            end
            BRP_WAIT: begin
                if (wait_q == 2'(WAIT_CYCLES)) begin
                    state_d = BRP_DATA;
                end
            end
            BRP_DATA: begin
                if (!last_n && fifo_ready) begin
                    state_d = BRP_RECOVER;
                end
            end
            BRP_RECOVER: begin
                state_d = BRP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state_q <= BRP_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            wait_q <= 2'h0;
        end else if (state_q == BRP_ADDR) begin
            wait_q <= WAIT_ONE;
        end else if (state_q == BRP_WAIT) begin
            wait_q <= wait_q + WAIT_ONE;
        end
    end

    // Latch follows the pins while idle, clears in reset, and recaptures when the strobe is released in BRP_ADDR or BRP_WAIT
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            latch_q <= '0;
        end else if (state_q == BRP_IDLE) begin
            latch_q <= addr_sync_q;
        end else if (ads_n && !ads_prev_q
                     && (state_q == BRP_ADDR || state_q == BRP_WAIT)) begin
            latch_q <= addr_sync_q;
        end
    end

    assign emit = (state_q == BRP_DATA) && fifo_ready;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            byte_q  <= '0;
            beats_q <= '0;
        end else if (state_q == BRP_ADDR) begin
            byte_q  <= addr_sync_q[BYTE_SEL_W-1:0];
            beats_q <= '0;
        end else if (emit) begin
            byte_q  <= (byte_q == BYTE_LAST) ? '0 : byte_q + BYTE_ONE;
            beats_q <= beats_q + BYTE_ONE;
        end
    end

    // ----------------------------------------
    // Array and output path
    // ----------------------------------------
    // Array read is one cycle, so the address leads the beat by a cycle
    assign pgm_write = !pgm_n && pgm_prev_q && !sel_n && state_q == BRP_IDLE;
    assign rom_addr  = (state_q == BRP_IDLE) ? addr_sync_q
                     : {latch_q[ADDR_W-1:BYTE_SEL_W], byte_q};

    brp_rom #(
        .AW (ADDR_W)
    ) u_rom (
        .i_clk   (i_clk),
        .i_addr  (rom_addr),
        .o_data  (rom_data),
        .i_wr    (pgm_write),
        .i_wdata (wd_sync_q)
    );

    logic emit_q;
    logic beat_ready_unused;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            emit_q <= 1'b0;
        end else begin
            emit_q <= emit;
        end
    end

    brp_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FDEPTH)
    ) u_fifo (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_flush  (1'b0),
        .i_valid  (emit_q),
        .i_data   (rom_data),
        .o_ready  (beat_ready_unused),
        .o_valid  (o_beat_valid),
        .o_data   (o_beat_data),
        .i_ready  (i_beat_ready)
    );

    // One slot of slack covers the beat still in the read pipe
    logic [$clog2(FDEPTH+1)-1:0] pend_q;
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_q + ($bits(pend_q))'(emit)
                    - ($bits(pend_q))'(o_beat_valid && i_beat_ready);
        end
    end
    assign fifo_ready = beat_ready_unused && (pend_q < ($bits(pend_q))'(FDEPTH - 1));

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_byte_data      <= '0;
            o_byte_data_oe_n <= 1'b1;
            o_busy           <= 1'b0;
        end else begin
            o_byte_data      <= rom_data;
            o_byte_data_oe_n <= !emit_q;
            // Busy also covers bytes still in the read pipe
            o_busy           <= (state_d != BRP_IDLE) || emit || emit_q;
        end
    end
endmodule

// ==== verification/brp_bus_master.sv ====
`timescale 1ns/1ps
module brp_bus_master
    import brp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_resetn,
    input  wire logic              i_go,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_busy,
    output logic                   o_select_n,
    output logic                   o_strobe_n,
    output logic                   o_final_n,
    output logic      [ADDR_W-1:0] o_addr
);
    logic [3:0]        cyc_q;
    logic [ADDR_W-1:0] addr_q;
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cyc_q <= 4'hf;
        end else if (i_go) begin
            cyc_q <= 4'h0;
        end else if (cyc_q != 4'hf) begin
            cyc_q <= cyc_q + 4'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_go) begin
            addr_q <= i_addr;
        end
    end
    // Select drops mid-burst on purpose
    assign o_select_n = cyc_q > 4'h2;
    assign o_strobe_n = cyc_q != 4'h1;
    // Released lines show the inverse, so a stale capture is caught
    assign o_addr = (cyc_q < 4'h6) ? addr_q : ~addr_q;
    // Two pin stages delay it, so it drops before the first byte shows
    assign o_final_n = !(cyc_q >= 4'h7 && cyc_q != 4'hf && i_busy);
endmodule

// ==== verification/brp_top_sva.sv ====
`timescale 1ns/1ps
module brp_top_sva
    import brp_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_resetn,
    input wire logic              i_select_n,
    input wire logic              i_final_beat_n,
    input wire logic              i_beat_ready,
    input wire logic              o_byte_data_oe_n,
    input wire logic              o_beat_valid,
    input wire logic [DATA_W-1:0] o_beat_data,
    input wire logic              o_busy
);
    logic [2:0] cnt_q;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    always_ff @(posedge i_clk) begin
        if (!i_resetn || !o_busy) begin
            cnt_q <= 3'h0;
        end else if (!o_byte_data_oe_n) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
    sequence s_sel;
        (!o_busy && $fell(i_select_n)) ##1 !i_select_n [*2];
    endsequence
    sequence s_last;
        $rose(o_byte_data_oe_n) && !i_final_beat_n;
    endsequence
    property p_start; s_sel |-> ##[0:3] o_busy; endproperty
    a_start: assert property (p_start) else $error("no burst after select");
    property p_end; s_last |-> ##[0:4] !o_busy; endproperty
    a_end: assert property (p_end) else $error("burst not ended");
    property p_wait; $rose(o_busy) |-> o_byte_data_oe_n [*2]; endproperty
    a_wait: assert property (p_wait) else $error("no wait cycles");
    property p_drive; !o_byte_data_oe_n |-> o_busy; endproperty
    a_drive: assert property (p_drive) else $error("driven while idle");
    property p_count; cnt_q <= 3'h4; endproperty
    a_count: assert property (p_count) else $error("over four bytes");
    property p_hold;
        o_busy && i_final_beat_n && $past(i_final_beat_n) && $past(i_final_beat_n, 2)
            |=> o_busy;
    endproperty
    a_hold: assert property (p_hold) else $error("burst stopped early");
    property p_stream;
        o_beat_valid && !i_beat_ready |=> o_beat_valid && $stable(o_beat_data);
    endproperty
    a_stream: assert property (p_stream) else $error("beat lost");
    property p_reset;
        disable iff (1'b0) !i_resetn |=> o_byte_data_oe_n && !o_busy && !o_beat_valid;
    endproperty
    a_reset: assert property (p_reset) else $error("reset not idle");
endmodule
bind brp_top brp_top_sva u_brp_top_sva (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_select_n(i_select_n), .i_final_beat_n(i_final_beat_n),
    .i_beat_ready(i_beat_ready), .o_byte_data_oe_n(o_byte_data_oe_n),
    .o_beat_valid(o_beat_valid), .o_beat_data(o_beat_data), .o_busy(o_busy));

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import brp_pkg::*;
    logic              clk = 0, rstn = 0, go = 0, rdy = 1, pg_n = 1, tsel = 1;
    logic              tfin = 1, prg = 0, mon = 0, msel, mstb, mfin, oe, vld, busy;
    logic [ADDR_W-1:0] ta = '0, ma = '0, mad;
    logic [DATA_W-1:0] td = '0, pd, sd;
    logic [31:0]       lf = 32'h17aa5b7a, r = 32'h17aa5b7a;
    logic [14:0]       bk [3] = '{15'h0000, 15'h7fff, 15'h2a5c};
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] qp [$], qs [$];
    int                err_count = 0, n_checks = 0, w;
    always #20 clk = ~clk;
    function automatic logic [31:0] nx(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic prog(input logic [ADDR_W-1:0] a);
        r = nx(r);
        mem[a] = r[7:0];
        ta <= a;
        td <= r[7:0];
        repeat (4) @(posedge clk);
        tsel <= 0;
        pg_n <= 0;
        repeat (2) @(posedge clk);
        tsel <= 1;
        pg_n <= 1;
        repeat (12) @(posedge clk);
    endtask
    task automatic burst(input logic [ADDR_W-1:0] a);
        for (int i = 0; i < 4; i++) begin
            qp.push_back(mem[{a[16:2], 2'(a[1:0] + 2'(i))}]);
            qs.push_back(mem[{a[16:2], 2'(a[1:0] + 2'(i))}]);
        end
        ma <= a;
        go <= 1;
        @(posedge clk);
        go <= 0;
        for (w = 0; w < 80 && (qp.size() || qs.size() || busy); w++) @(posedge clk);
        chk("left", 8'h0, 8'(qp.size() + qs.size()));
        repeat (6) @(posedge clk);
    endtask
    always @(posedge clk) begin
        lf <= nx(lf);
        rdy <= lf[0] | lf[1];
        if (mon && !oe) chk("pin", qp.size() ? qp.pop_front() : 8'hxx, pd);
        if (mon && vld && rdy) chk("beat", qs.size() ? qs.pop_front() : 8'hxx, sd);
    end
    brp_bus_master u_brp_bus_master (.i_clk(clk), .i_resetn(rstn), .i_go(go),
        .i_addr(ma), .i_busy(busy), .o_select_n(msel),
        .o_strobe_n(mstb), .o_final_n(mfin), .o_addr(mad));
    brp_top u_brp_top (.i_clk(clk), .i_resetn(rstn), .i_select_n(msel & tsel),
        .i_addr_valid_strobe_n(mstb), .i_final_beat_n(mfin & tfin),
        .i_byte_address(prg ? ta : mad), .i_program_pulse_n(pg_n), .i_byte_data(td),
        .o_byte_data(pd), .o_byte_data_oe_n(oe), .o_beat_valid(vld), .o_beat_data(sd),
        .i_beat_ready(rdy), .o_busy(busy));
    initial begin
        #1200000;
        err_count++;
        complete_run;
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1;
        repeat (5) @(posedge clk);
        tfin <= 0;
        prg <= 1;
        foreach (bk[b]) for (int k = 0; k < 4; k++) prog({bk[b], 2'(k)});
        tfin <= 1;
        prg <= 0;
        $display("program done");
        ma <= {bk[0], 2'h1};
        go <= 1;
        @(posedge clk);
        go <= 0;
        for (w = 0; w < 40 && oe !== 1'b0; w++) @(posedge clk);
        chk("start", 8'h0, {7'h0, oe});
        rstn <= 0;
        repeat (10) @(posedge clk);
        chk("busy", 8'h0, {7'h0, busy});
        chk("oe", 8'h1, {7'h0, oe});
        chk("vld", 8'h0, {7'h0, vld});
        rstn <= 1;
        repeat (5) @(posedge clk);
        mon <= 1;
        $display("reset abort done");
        foreach (bk[b]) for (int k = 0; k < 4; k++) burst({bk[b], 2'(k)});
        $display("bursts done");
        complete_run;
    end
endmodule
